// ==== core/dual_log_pot_serial_control.sv ====
// Two-wire slave and wiper registers of a dual log potentiometer
`timescale 1ns/1ps
`include "pot_params.svh"

module dual_log_pot_serial_control #(
  parameter logic [3:0] DEVICE_TYPE_ID = 4'h9, // Arbitrary value
  parameter int SYNC_STAGES = 2,
  parameter int TAP_BITS = `TAP_BITS
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic addr_pin_high,
  input wire logic addr_pin_low,
  input wire logic zero_cross_detect,
  output logic [(1<<TAP_BITS)-1:0] left_tap_sel,
  output logic [(1<<TAP_BITS)-1:0] right_tap_sel,
  output logic [7:0] left_atten_db,
  output logic [7:0] right_atten_db
);

  // ==========================================================
  // Parameter checks
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("at least two synchroniser stages are needed");
  end
  if (TAP_BITS != `TAP_BITS) begin : g_bad_taps
    $error("wiper width is fixed by the byte format");
  end

  localparam int NSYNC = 6; // scl, sda, two pins, zero cross, toggle
  // Reset shows an idle bus, so no false clock edge follows release
  localparam logic [NSYNC-1:0] SYNC_IDLE = 6'h03;

  // ==========================================================
  // Link domain: sample data on each rising serial clock
  logic bit_tgl_r; // Flips once per rising edge
  logic bit_tgl_nxt;
  logic bit_val_r; // Held for a whole clock period, read after toggle
  logic bit_val_nxt;

  // Next values in the link domain
  always_comb begin
    bit_tgl_nxt = ~bit_tgl_r;
    bit_val_nxt = sda_i;
  end

  // Link registers; data stays put while the toggle crosses
  always_ff @(posedge scl or negedge nrst) begin
    if (!nrst) begin
      bit_tgl_r <= 1'b0;
      bit_val_r <= 1'b0;
    end else begin
      bit_tgl_r <= bit_tgl_nxt;
      bit_val_r <= bit_val_nxt;
    end
  end

  // ==========================================================
  // Synchronisers into the system domain
  logic [NSYNC-1:0] sync_in; // Raw levels
  logic [NSYNC-1:0] sync_r [SYNC_STAGES]; // Stage 0 feeds stage 1 only
  logic [NSYNC-1:0] sync_out; // Last stage
  logic scl_s;
  logic sda_s;
  logic pin_hi_s;
  logic pin_lo_s;
  logic zc_s;
  logic tgl_s;

  // Undriven address pins rely on their pull-downs to read zero
  assign sync_in = {bit_tgl_r, zero_cross_detect, addr_pin_low, addr_pin_high, sda_i, scl};

  // Plain shift chain, one register per stage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < SYNC_STAGES; k++) begin
        sync_r[k] <= SYNC_IDLE;
      end
    end else begin
      sync_r[0] <= sync_in;
      for (int k = 1; k < SYNC_STAGES; k++) begin
        sync_r[k] <= sync_r[k-1];
      end
    end
  end

  assign sync_out = sync_r[SYNC_STAGES-1];
  assign {tgl_s, zc_s, pin_lo_s, pin_hi_s, sda_s, scl_s} = sync_out;

  // ==========================================================
  // Edge detection on synchronised levels
  logic scl_d_r; // Previous levels
  logic sda_d_r;
  logic tgl_d_r;
  pot_pkg::link_event_type ev; // Bus events this cycle

  // Previous-level registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      tgl_d_r <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      tgl_d_r <= tgl_s;
    end
  end

  // Data moving while clock is high marks frame edges
  always_comb begin
    ev.start = scl_s & scl_d_r & sda_d_r & ~sda_s;
    ev.stop = scl_s & scl_d_r & ~sda_d_r & sda_s;
    ev.scl_fall = scl_d_r & ~scl_s;
    ev.bit_seen = tgl_s ^ tgl_d_r;
    ev.bit_val = bit_val_r;
  end

  // ==========================================================
  // Protocol state
  pot_pkg::state_type state_r, state_nxt;
  pot_pkg::state_type after_r, after_nxt; // State after acknowledge
  logic [2:0] cnt_r, cnt_nxt; // Bits done in this byte
  logic [7:0] shift_r, shift_nxt; // Received bits
  logic [7:0] tx_r, tx_nxt; // Byte being sent
  logic tx_right_r, tx_right_nxt; // Right byte is being sent
  logic seen_r, seen_nxt; // Ninth rising edge passed
  logic drv_r, drv_nxt; // Pulling data low
  logic second_r, second_nxt; // Next data byte is the right one
  pot_pkg::cmd_byte_type cmd_r, cmd_nxt; // Accepted command
  logic [7:0] rx_byte; // Byte including the current bit
  pot_pkg::slave_byte_type sb; // Address view of rx_byte
  pot_pkg::cmd_byte_type cb; // Command view of rx_byte
  logic [1:0] wr_req; // Load request per channel, 0 left
  logic [1:0] step_req; // Step request per channel
  logic [TAP_BITS-1:0] wr_val; // Value to load
  logic [1:0][TAP_BITS-1:0] wiper_r, wiper_nxt; // Wiper registers

  // Next protocol state; start and stop outrank everything
  always_comb begin
    state_nxt = state_r;
    after_nxt = after_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    tx_nxt = tx_r;
    tx_right_nxt = tx_right_r;
    seen_nxt = seen_r;
    drv_nxt = drv_r;
    second_nxt = second_r;
    cmd_nxt = cmd_r;
    wr_req = 2'b00;
    step_req = 2'b00;
    rx_byte = {shift_r[6:0], ev.bit_val};
    sb = rx_byte;
    cb = rx_byte;
    wr_val = rx_byte[TAP_BITS-1:0];
    if (ev.start) begin
      state_nxt = pot_pkg::ST_ADDR;
      cnt_nxt = 3'h0;
      drv_nxt = 1'b0;
    end else if (ev.stop) begin
      state_nxt = pot_pkg::ST_IDLE;
      drv_nxt = 1'b0;
    end else begin
      case (state_r)
        pot_pkg::ST_IDLE: begin
          drv_nxt = 1'b0;
        end
        pot_pkg::ST_ADDR, pot_pkg::ST_CMD, pot_pkg::ST_DATA: begin
          if (ev.bit_seen) begin
            shift_nxt = rx_byte;
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == `BIT_LAST) begin
              seen_nxt = 1'b0;
              state_nxt = pot_pkg::ST_ACK;
              if (state_r == pot_pkg::ST_ADDR) begin
                // Type, fixed bit and both pins must match
                if (sb.type_id != DEVICE_TYPE_ID || sb.fixed_bit != `ADDR_FIXED_BIT ||
                    sb.addr_pin_high != pin_hi_s || sb.addr_pin_low != pin_lo_s) begin
                  state_nxt = pot_pkg::ST_IDLE;
                end else if (sb.read) begin
                  after_nxt = pot_pkg::ST_TX;
                end else begin
                  after_nxt = pot_pkg::ST_CMD;
                end
              end else if (state_r == pot_pkg::ST_CMD) begin
                cmd_nxt = cb;
                second_nxt = 1'b0;
                if (!cb.left_pot_select && !cb.right_pot_select) begin
                  state_nxt = pot_pkg::ST_IDLE;
                end else if (cb.opcode == `OP_DIRECT_WRITE) begin
                  after_nxt = pot_pkg::ST_DATA;
                end else if (cb.opcode == `OP_STEP_MODE) begin
                  after_nxt = pot_pkg::ST_STEP;
                end else begin
                  state_nxt = pot_pkg::ST_IDLE;
                end
              end else begin
                // Both selected: left byte first, then right
                if (cmd_r.left_pot_select && cmd_r.right_pot_select) begin
                  wr_req = second_r ? 2'b10 : 2'b01;
                  after_nxt = second_r ? pot_pkg::ST_IDLE : pot_pkg::ST_DATA;
                  second_nxt = 1'b1;
                end else begin
                  wr_req = {cmd_r.right_pot_select, cmd_r.left_pot_select};
                  after_nxt = pot_pkg::ST_IDLE;
                end
              end
            end
          end
        end
        pot_pkg::ST_ACK: begin
          // Pull low on the fall after the eighth bit, release after the ninth
          if (ev.bit_seen) begin
            seen_nxt = 1'b1;
          end
          if (ev.scl_fall && !seen_r) begin
            drv_nxt = 1'b1;
          end else if (ev.scl_fall && seen_r) begin
            state_nxt = after_r;
            cnt_nxt = 3'h0;
            seen_nxt = 1'b0;
            drv_nxt = 1'b0;
            if (after_r == pot_pkg::ST_TX) begin
              tx_nxt = 8'(wiper_r[0]);
              tx_right_nxt = 1'b0;
              drv_nxt = ~tx_nxt[`BIT_LAST];
            end
          end
        end
        pot_pkg::ST_TX: begin
          // Bits change only on a falling clock
          if (ev.bit_seen) begin
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == `BIT_LAST) begin
              state_nxt = pot_pkg::ST_TX_ACK;
            end
          end
          if (ev.scl_fall) begin
            drv_nxt = ~tx_r[3'(`BIT_LAST - cnt_r)];
          end
        end
        pot_pkg::ST_TX_ACK: begin
          if (ev.scl_fall) begin
            drv_nxt = 1'b0;
          end
          // Master acks the left byte to get the right one
          if (ev.bit_seen) begin
            if (!ev.bit_val && !tx_right_r) begin
              state_nxt = pot_pkg::ST_TX;
              tx_nxt = 8'(wiper_r[1]);
              tx_right_nxt = 1'b1;
              cnt_nxt = 3'h0;
            end else begin
              state_nxt = pot_pkg::ST_IDLE;
            end
          end
        end
        pot_pkg::ST_STEP: begin
          // Step as the high pulse ends, so the clock rise of a stop never counts
          if (ev.bit_seen) begin
            seen_nxt = 1'b1;
          end
          if (ev.scl_fall && seen_r) begin
            seen_nxt = 1'b0;
            step_req = {cmd_r.right_pot_select, cmd_r.left_pot_select};
          end
        end
        default: begin
          state_nxt = pot_pkg::ST_IDLE;
          drv_nxt = 1'b0;
        end
      endcase
    end
  end

  // Protocol registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= pot_pkg::ST_IDLE;
      after_r <= pot_pkg::ST_IDLE;
      cnt_r <= 3'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      tx_right_r <= 1'b0;
      seen_r <= 1'b0;
      drv_r <= 1'b0;
      second_r <= 1'b0;
      cmd_r <= '0;
    end else begin
      state_r <= state_nxt;
      after_r <= after_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      tx_r <= tx_nxt;
      tx_right_r <= tx_right_nxt;
      seen_r <= seen_nxt;
      drv_r <= drv_nxt;
      second_r <= second_nxt;
      cmd_r <= cmd_nxt;
    end
  end

  // ==========================================================
  // Wiper registers with optional zero-cross deferral
  logic [1:0][TAP_BITS-1:0] pend_r, pend_nxt; // Deferred value
  logic [1:0] pend_v_r, pend_v_nxt; // Deferred value waiting
  logic [TAP_BITS-1:0] base; // Latest requested position
  logic [TAP_BITS-1:0] target; // New position for this channel

  // Loads and steps; deferral trades latency for click-free changes
  always_comb begin
    wiper_nxt = wiper_r;
    pend_nxt = pend_r;
    pend_v_nxt = pend_v_r;
    base = '0;
    target = '0;
    for (int i = 0; i < 2; i++) begin
      base = pend_v_r[i] ? pend_r[i] : wiper_r[i];
      target = wr_val;
      if (step_req[i]) begin
        // Saturate at both ends
        if (ev.bit_val) begin
          target = (base == `WIPER_TOP) ? base : base + 5'h01;
        end else begin
          target = (base == `WIPER_RESET) ? base : base - 5'h01;
        end
      end
      if (wr_req[i] || step_req[i]) begin
        if (cmd_r.zero_cross_switch_enable) begin
          pend_nxt[i] = target;
          pend_v_nxt[i] = 1'b1;
        end else begin
          wiper_nxt[i] = target;
          pend_v_nxt[i] = 1'b0;
        end
      end
      if (pend_v_nxt[i] && zc_s) begin
        wiper_nxt[i] = pend_nxt[i];
        pend_v_nxt[i] = 1'b0;
      end
    end
  end

  // Volatile wipers reset to mute
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wiper_r <= {2{`WIPER_RESET}};
      pend_r <= {2{`WIPER_RESET}};
      pend_v_r <= 2'b00;
    end else begin
      wiper_r <= wiper_nxt;
      pend_r <= pend_nxt;
      pend_v_r <= pend_v_nxt;
    end
  end

  // ==========================================================
  // Tap decode, registered so every output is a flop
  logic [1:0][(1<<TAP_BITS)-1:0] sel_c, sel_r; // One-hot switches
  logic [1:0][7:0] att_c, att_r; // Attenuation in dB

  for (genvar g = 0; g < 2; g++) begin : g_dec
    tap_decoder #(
      .TAP_BITS(TAP_BITS)
    ) u_dec (
      .wiper_position(wiper_r[g]),
      .tap_sel(sel_c[g]),
      .atten_db(att_c[g])
    );
  end

  // Output registers; reset shows the mute switch alone
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sel_r <= {2{`SEL_RESET}};
      att_r <= {2{`ATT_MUTE}};
      sda_o <= 1'b0;
    end else begin
      sel_r <= sel_c;
      att_r <= att_c;
      sda_o <= 1'b0;
    end
  end

  assign sda_oe = drv_r;
  assign left_tap_sel = sel_r[0];
  assign right_tap_sel = sel_r[1];
  assign left_atten_db = att_r[0];
  assign right_atten_db = att_r[1];

endmodule : dual_log_pot_serial_control

// ==== core/pot_params.svh ====
// Constants for the dual log potentiometer serial control logic
`ifndef POT_PARAMS_SVH
`define POT_PARAMS_SVH

// ==========================================================
// Wiper registers
`define TAP_BITS 5
`define TAP_COUNT 32
`define WIPER_RESET 5'h00
`define WIPER_TOP 5'h1f
`define SEL_RESET 32'h0000_0001

// ==========================================================
// Serial framing
`define BIT_LAST 3'h7
`define ADDR_FIXED_BIT 1'b0
`define OP_DIRECT_WRITE 4'ha
`define OP_STEP_MODE 4'h2

// ==========================================================
// Attenuation segments, in dB
`define ATT_MUTE 8'ha4
`define SEG_A_FIRST 5'h14
`define SEG_B_FIRST 5'h0a
`define SEG_C_FIRST 5'h05
`define SEG_D_FIRST 5'h01
`define SEG_A_OFS 8'h1f
`define SEG_B_OFS 8'h33
`define SEG_C_OFS 8'h3d
`define SEG_D_OFS 8'h42

`endif

// ==== core/pot_pkg.sv ====
// Types for the dual log potentiometer serial control logic
package pot_pkg;

  // ==========================================================
  // Protocol states, Gray-coded in the order listed
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ACK = 4'h3,
    ST_CMD = 4'h2,
    ST_DATA = 4'h6,
    ST_STEP = 4'h7,
    ST_TX = 4'h5,
    ST_TX_ACK = 4'h4
  } state_type;

  // ==========================================================
  // Slave address byte layout, first bit on the wire at the top
  typedef struct packed {
    logic [3:0] type_id;
    logic fixed_bit;
    logic addr_pin_high;
    logic addr_pin_low;
    logic read;
  } slave_byte_type;

  // Command byte layout
  typedef struct packed {
    logic [3:0] opcode;
    logic spare;
    logic zero_cross_switch_enable;
    logic right_pot_select;
    logic left_pot_select;
  } cmd_byte_type;

  // Events seen on the bus, in the system clock domain
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_fall;
    logic bit_seen;
    logic bit_val;
  } link_event_type;

endpackage : pot_pkg

// ==== core/tap_decoder.sv ====
// One-hot tap switch decode and attenuation lookup for one wiper
`timescale 1ns/1ps
`include "pot_params.svh"

module tap_decoder #(
  parameter int TAP_BITS = `TAP_BITS
) (
  input wire logic [TAP_BITS-1:0] wiper_position,
  output logic [(1<<TAP_BITS)-1:0] tap_sel,
  output logic [7:0] atten_db
);

  // ==========================================================
  // Width check
  if (TAP_BITS != `TAP_BITS) begin : g_bad_width
    $error("tap_decoder serves only the documented wiper width");
  end

  logic [7:0] pos_ext; // Position widened for signed arithmetic

  // ==========================================================
  // Exactly one switch on for any position
  always_comb begin
    tap_sel = '0;
    tap_sel[wiper_position] = 1'b1;
  end

  // ==========================================================
  // Piecewise log law, two's complement dB
  always_comb begin
    pos_ext = 8'(wiper_position);
    if (wiper_position >= `SEG_A_FIRST) begin
      atten_db = pos_ext - `SEG_A_OFS;
    end else if (wiper_position >= `SEG_B_FIRST) begin
      atten_db = 8'(pos_ext << 1) - `SEG_B_OFS;
    end else if (wiper_position >= `SEG_C_FIRST) begin
      atten_db = 8'(pos_ext * 8'h03) - `SEG_C_OFS;
    end else if (wiper_position >= `SEG_D_FIRST) begin
      atten_db = 8'(pos_ext << 2) - `SEG_D_OFS;
    end else begin
      atten_db = `ATT_MUTE;
    end
  end

endmodule : tap_decoder

// ==== dv/pot_master_model.sv ====
// Two-wire bus master model that drives the serial side of the pot control
`timescale 1ns/1ps

module pot_master_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // ==========================================================
  // Bus phases
  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // One clock phase; not a multiple of the system period on purpose
  task automatic ph();
    #103;
  endtask : ph

  // Start: data falls while clock high, also usable as repeated start
  task automatic start_c();
    sda_low = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    sda_low = 1'b1;
    ph();
    scl = 1'b0;
    #20;
  endtask : start_c

  // Stop: data rises while clock high
  task automatic stop_c();
    sda_low = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    sda_low = 1'b0;
    ph();
  endtask : stop_c

  // One bit: data set only while clock low, sampled before clock falls
  task automatic bit_c(input logic b, output logic s);
    sda_low = !b;
    ph();
    scl = 1'b1;
    ph();
    s = sda;
    scl = 1'b0;
    #20;
  endtask : bit_c

  // Byte out, then release data for the slave acknowledge on clock nine
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(b[i], s);
    bit_c(1'b1, s);
    ack = !s;
  endtask : wr_byte

  // Byte in with data released; master acknowledge pulls data low on clock nine
  task automatic rd_byte(output logic [7:0] b, input logic mack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(1'b1, b[i]);
    bit_c(!mack, s);
  endtask : rd_byte

  // One step pulse: data level tells the direction
  task automatic step(input logic up);
    logic s;
    bit_c(up, s);
  endtask : step
endmodule : pot_master_model

// ==== dv/pot_ctrl_monitor.sv ====
// Port checker for the dual log potentiometer control block
`timescale 1ns/1ps

module pot_ctrl_monitor #(
  parameter int TAP_BITS = 5
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic zero_cross_detect,
  input wire logic [(1<<TAP_BITS)-1:0] left_tap_sel,
  input wire logic [(1<<TAP_BITS)-1:0] right_tap_sel,
  input wire logic [7:0] left_atten_db,
  input wire logic [7:0] right_atten_db
);
  // ==========================================================
  // Expected attenuation of a one-hot select, from the tap law
  function automatic logic [7:0] law(input logic [(1<<TAP_BITS)-1:0] s);
    int n;
    n = 0;
    for (int i = 0; i < (1<<TAP_BITS); i++) if (s[i]) n = i;
    if (n >= 20) return 8'(n - 31);
    if (n >= 10) return 8'(2 * n - 51);
    if (n >= 5) return 8'(3 * n - 61);
    if (n >= 1) return 8'(4 * n - 66);
    return 8'ha4;
  endfunction : law

  // ==========================================================
  // Properties, all in the system clock domain
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_left_onehot; $onehot(left_tap_sel); endproperty
  property p_right_onehot; $onehot(right_tap_sel); endproperty
  property p_left_law; left_atten_db == law(left_tap_sel); endproperty
  property p_right_law; right_atten_db == law(right_tap_sel); endproperty
  // Open drain: the value pin never carries a high
  property p_open_drain; sda_o == 1'b0; endproperty
  // Pull starts and ends only while the clock is low
  property p_pull_rise; $rose(sda_oe) |-> !scl; endproperty
  property p_pull_fall; $fell(sda_oe) |-> !scl; endproperty
  // First edge after release still shows the mute tap
  property p_reset_mute;
    $rose(nrst) |-> left_tap_sel == 32'h0000_0001 && right_atten_db == 8'ha4;
  endproperty

  a_left_onehot: assert property (p_left_onehot) else $error("left select not one-hot");
  a_right_onehot: assert property (p_right_onehot) else $error("right select not one-hot");
  a_left_law: assert property (p_left_law) else $error("left dB wrong");
  a_right_law: assert property (p_right_law) else $error("right dB wrong");
  a_open_drain: assert property (p_open_drain) else $error("data driven high");
  a_pull_rise: assert property (p_pull_rise) else $error("pull began in clock high");
  a_pull_fall: assert property (p_pull_fall) else $error("pull ended in clock high");
  a_reset_mute: assert property (p_reset_mute) else $error("not mute after reset");

  // Main scenarios seen
  c_ack: cover property ($rose(sda_oe));
  c_left_move: cover property ($changed(left_tap_sel));
  c_zero_wait: cover property (zero_cross_detect && $changed(right_tap_sel));
endmodule : pot_ctrl_monitor

bind dual_log_pot_serial_control pot_ctrl_monitor #(.TAP_BITS(TAP_BITS)) u_mon (
  .clk_sys(clk_sys), .nrst(nrst), .scl(scl), .sda_o(sda_o), .sda_oe(sda_oe),
  .zero_cross_detect(zero_cross_detect), .left_tap_sel(left_tap_sel),
  .right_tap_sel(right_tap_sel), .left_atten_db(left_atten_db),
  .right_atten_db(right_atten_db));

// ==== dv/tb_top.sv ====
// Self-checking bench for the dual log potentiometer control block
`timescale 1ns/1ps

module tb_top;
  // ==========================================================
  // Setup
  localparam logic [3:0] TYPE_ID = 4'h6; // Arbitrary value
  localparam logic [7:0] ADDR_W = {TYPE_ID, 4'h4}; // Pins high=1, low=0, write
  logic clk_sys = 1'b0;
  logic nrst = 1'b1;
  logic addr_pin_high = 1'b1;
  logic addr_pin_low = 1'b0;
  logic zero_cross_detect = 1'b0;
  logic [7:0] v;
  wire logic scl, sda_low, sda_o, sda_oe;
  wire logic [31:0] left_tap_sel, right_tap_sel;
  wire logic [7:0] left_atten_db, right_atten_db;
  // Pulled-up wire: low while either party pulls
  wire logic sda = !(sda_low || sda_oe);
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;

  always #5 clk_sys = ~clk_sys;

  dual_log_pot_serial_control #(.DEVICE_TYPE_ID(TYPE_ID)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .scl(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .addr_pin_high(addr_pin_high), .addr_pin_low(addr_pin_low),
    .zero_cross_detect(zero_cross_detect), .left_tap_sel(left_tap_sel),
    .right_tap_sel(right_tap_sel), .left_atten_db(left_atten_db),
    .right_atten_db(right_atten_db));

  pot_master_model m (.scl(scl), .sda_low(sda_low), .sda(sda));

  // ==========================================================
  // Shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic a;
    m.wr_byte(b, a);
    chk(32'(a), 32'(exp_ack));
  endtask : send

  // Whole frame; bit i of ak is the expected acknowledge of byte i
  task automatic frame(input int n, input logic [7:0] b [5], input logic [4:0] ak);
    m.start_c();
    for (int i = 0; i < n; i++) send(b[i], ak[i]);
    m.stop_c();
  endtask : frame

  // Let the wiper settle, then compare both tap selects
  task automatic taps(input logic [4:0] l, input logic [4:0] r);
    repeat (8) @(posedge clk_sys);
    chk(left_tap_sel, 32'h0000_0001 << l);
    chk(right_tap_sel, 32'h0000_0001 << r);
  endtask : taps

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    taps(5'd0, 5'd0);
    chk(32'(left_atten_db), 32'h0000_00a4);
    $display("reset test done");
  endtask : t_reset

  task automatic t_write();
    frame(3, '{ADDR_W, 8'ha1, 8'h10, 0, 0}, 5'b00111);
    taps(5'd16, 5'd0);
    chk(32'(left_atten_db), 32'h0000_00ed);
    frame(3, '{ADDR_W, 8'ha2, 8'hff, 0, 0}, 5'b00111);
    taps(5'd16, 5'd31);
    frame(5, '{ADDR_W, 8'ha3, 8'h05, 8'h01, 8'h33}, 5'b01111);
    taps(5'd5, 5'd1);
    chk(32'(right_atten_db), 32'h0000_00c2);
    $display("write test done");
  endtask : t_write

  task automatic t_read();
    m.start_c();
    send(ADDR_W | 8'h01, 1'b1);
    m.rd_byte(v, 1'b1);
    chk(32'(v), 32'h0000_0005);
    m.rd_byte(v, 1'b0);
    chk(32'(v), 32'h0000_0001);
    m.stop_c();
    $display("read test done");
  endtask : t_read

  // Bad address or command: no acknowledge, rest of frame ignored
  task automatic t_refuse();
    frame(2, '{8'hc4, ADDR_W, 0, 0, 0}, 5'b00000);
    frame(2, '{{TYPE_ID, 4'h0}, 8'ha1, 0, 0, 0}, 5'b00000);
    frame(2, '{{TYPE_ID, 4'hc}, 8'ha1, 0, 0, 0}, 5'b00000);
    frame(3, '{ADDR_W, 8'h31, 8'h07, 0, 0}, 5'b00001);
    frame(3, '{ADDR_W, 8'ha0, 8'h07, 0, 0}, 5'b00001);
    taps(5'd5, 5'd1);
    $display("refuse test done");
  endtask : t_refuse

  task automatic t_step();
    m.start_c();
    send(ADDR_W, 1'b1);
    send(8'h23, 1'b1);
    repeat (28) m.step(1'b1);
    m.stop_c();
    taps(5'd31, 5'd29);
    frame(3, '{ADDR_W, 8'ha2, 8'h04, 0, 0}, 5'b00111);
    taps(5'd31, 5'd4);
    m.start_c();
    send(ADDR_W, 1'b1);
    send(8'h21, 1'b1);
    repeat (35) m.step(1'b0);
    m.stop_c();
    taps(5'd0, 5'd4);
    $display("step test done");
  endtask : t_step

  // Change held until near-zero detect, then new pin address
  task automatic t_zero_pins();
    frame(3, '{ADDR_W, 8'ha6, 8'h0a, 0, 0}, 5'b00111);
    taps(5'd0, 5'd4);
    @(posedge clk_sys);
    #1 zero_cross_detect = 1'b1;
    taps(5'd0, 5'd10);
    #1 zero_cross_detect = 1'b0;
    addr_pin_high = 1'b0;
    addr_pin_low = 1'b1;
    frame(3, '{ADDR_W, 8'ha1, 8'h1f, 0, 0}, 5'b00000);
    frame(3, '{{TYPE_ID, 4'h2}, 8'ha1, 8'h1f, 0, 0}, 5'b00111);
    taps(5'd31, 5'd10);
    $display("zero cross and pin test done");
  endtask : t_zero_pins

  // ==========================================================
  // Verdict and hang guard
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // Full run is about 11000 cycles; this ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      $display("timeout at %0t", $time);
      tally_and_finish();
    end
  end

  initial begin
    // A real falling edge, so the serial clock domain resets as well
    #1 nrst = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1 nrst = 1'b1;
    repeat (6) @(posedge clk_sys);
    t_reset();
    t_write();
    t_read();
    t_refuse();
    t_step();
    t_zero_pins();
    tally_and_finish();
  end
endmodule : tb_top
